// >>> hw/vme_glue_pkg.sv
package vme_glue_pkg;

    // address field layout of the bus address seen by the glue
    localparam int ADDR_W = 24;
    localparam int TOP_MSB = 23;
    localparam int TOP_LSB = 16;
    localparam int MID_MSB = 15;
    localparam int MID_LSB = 8;
    localparam int LOW_MSB = 3;
    localparam int LOW_LSB = 1;
    localparam logic [7:0] TOP_ALL_ONES = 8'hFF;
    localparam logic [7:0] MID_MATCH_RST = 8'h00;

    // acknowledge sequencer states, two flip-flops
    typedef enum logic [1:0] {
        ACK_IDLE = 2'b00,
        ACK_WAIT1 = 2'b01,
        ACK_WAIT2 = 2'b10,
        ACK_DONE = 2'b11
    } ack_state_t;

    // bus-side strobes and interrupt-ack qualifier, all active low; direction high for a read
    typedef struct packed {
        logic as_n;
        logic ds0_n;
        logic ds1_n;
        logic write_n;
        logic irq_ack_cycle_n;
    } bus_ctl_t;

    // controller-side strobes, active low
    typedef struct packed {
        logic controller_select_n;
        logic rd_n;
        logic wr_n;
    } ctl_strobe_t;

    // whole state of the glue
    typedef struct packed {
        logic [ADDR_W-1:0] addr_s1;
        logic [ADDR_W-1:0] addr_s2;
        bus_ctl_t ctl_s1;
        bus_ctl_t ctl_s2;
        ack_state_t ack;
        ctl_strobe_t strobe;
        logic dtack_n;
        logic drv_en;
        logic drv_to_bus;
        logic [LOW_MSB-LOW_LSB:0] reg_sel;
    } glue_state_t;

    localparam bus_ctl_t BUS_CTL_IDLE = 5'h1F;
    localparam ctl_strobe_t STROBE_IDLE = 3'h7;

endpackage

// >>> hw/vme_to_graphics_glue.sv
// Overview of operation
// RL1 - select only when top eight address lines high
// RL2 - next eight lines compared, low lines aliased
// RL3 - glue itself produces bus data acknowledge
// RL4 - acknowledge comes only from this glue
// RL5 - qualify: board selected, data strobe, not irq-ack
// RL6 - acknowledge three clocks after qualification
// RL7 - acknowledge held while transfer stays qualified
// RL8 - four-state sequencer in two flip-flops
// RL9 - advance 00,01,10,11 then hold; else 00
// RL10 - system reset forces sequencer to zero
// RL11 - acknowledge low only in state eleven
// RL12 - read/write strobes from data strobes, direction
// RL13 - select needs address strobe, board, no irq-ack
// RL14 - DMA configuration steers bus data drivers
// RL15 - DMA configuration decodes low lines via multiplexer
// RL16 - master holds strobes until acknowledge seen
module vme_to_graphics_glue (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [vme_glue_pkg::ADDR_W-1:0] addr_i,
    input wire vme_glue_pkg::bus_ctl_t bus_ctl_i,
    input wire logic [7:0] mid_match_i,
    input wire logic dma_mode_i,
    output logic dtack_n_o,
    output vme_glue_pkg::ctl_strobe_t strobe_o,
    output logic drv_en_o,
    output logic drv_to_bus_o,
    output logic [vme_glue_pkg::LOW_MSB-vme_glue_pkg::LOW_LSB:0] reg_sel_o
);
    import vme_glue_pkg::*;

    glue_state_t s_q;
    glue_state_t s_d;

    // decoded terms, taken from the synchronised bus copies plus the unsynchronised mid_match_i and dma_mode_i
    logic top_hit;
    logic mid_hit;
    logic board_sel;
    logic any_ds;
    logic not_irq_ack;
    logic qualified;
    logic [LOW_MSB-LOW_LSB:0] low_mux;

    // board select; the low lines are left out so the window aliases
    always_comb begin
        top_hit = (s_q.addr_s2[TOP_MSB:TOP_LSB] == TOP_ALL_ONES); // RL1
        mid_hit = (s_q.addr_s2[MID_MSB:MID_LSB] == mid_match_i); // RL2
        board_sel = top_hit & mid_hit;
        any_ds = ~s_q.ctl_s2.ds0_n | ~s_q.ctl_s2.ds1_n;
        not_irq_ack = s_q.ctl_s2.irq_ack_cycle_n;
        qualified = board_sel & any_ds & not_irq_ack; // RL5
    end

    // low-line select for the dma setup: a plain multiplexer on the low address bits
    always_comb begin
        if (dma_mode_i) begin
            low_mux = s_q.addr_s2[LOW_MSB:LOW_LSB]; // RL15
        end else begin
            low_mux = '0;
        end
    end

    // next-state logic; bus inputs are asynchronous so they pass two flops first,
    // which adds fixed latency but keeps the sequencer free of metastable terms
    always_comb begin
        s_d = s_q;
        s_d.addr_s1 = addr_i;
        s_d.addr_s2 = s_q.addr_s1;
        s_d.ctl_s1 = bus_ctl_i;
        s_d.ctl_s2 = s_q.ctl_s1;
        if (!qualified) begin
            s_d.ack = ACK_IDLE; // RL9
        end else begin
            case (s_q.ack) // RL8
                ACK_IDLE: begin
                    s_d.ack = ACK_WAIT1; // RL9
                end
                ACK_WAIT1: begin
                    s_d.ack = ACK_WAIT2;
                end
                ACK_WAIT2: begin
                    s_d.ack = ACK_DONE; // RL6
                end
                ACK_DONE: begin
                    s_d.ack = ACK_DONE; // RL7
                end
                default: begin
                    s_d.ack = ACK_IDLE;
                end
            endcase
        end
        // acknowledge decoded from the next state so it lands with the state flops
        s_d.dtack_n = ~(s_d.ack == ACK_DONE); // RL11 RL3 RL4
        s_d.strobe.rd_n = ~(any_ds & s_q.ctl_s2.write_n); // RL12
        s_d.strobe.wr_n = ~(any_ds & ~s_q.ctl_s2.write_n);
        s_d.strobe.controller_select_n = ~(~s_q.ctl_s2.as_n & board_sel & not_irq_ack); // RL13
        // drivers only steered in dma mode; point toward the bus on reads
        s_d.drv_en = dma_mode_i & board_sel & any_ds & not_irq_ack; // RL14
        s_d.drv_to_bus = dma_mode_i & s_q.ctl_s2.write_n;
        s_d.reg_sel = low_mux;
    end

    // single state register; reset wins over every next-state term
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q.addr_s1 <= '0;
            s_q.addr_s2 <= '0;
            s_q.ctl_s1 <= BUS_CTL_IDLE;
            s_q.ctl_s2 <= BUS_CTL_IDLE;
            s_q.ack <= ACK_IDLE; // RL10
            s_q.strobe <= STROBE_IDLE;
            s_q.dtack_n <= 1'b1;
            s_q.drv_en <= 1'b0;
            s_q.drv_to_bus <= 1'b0;
            s_q.reg_sel <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dtack_n_o = s_q.dtack_n;
    assign strobe_o = s_q.strobe;
    assign drv_en_o = s_q.drv_en;
    assign drv_to_bus_o = s_q.drv_to_bus;
    assign reg_sel_o = s_q.reg_sel;

    // sequencer stays idle outside the top window
    AST_TOP_DECODE: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
        (s_q.addr_s2[TOP_MSB:TOP_LSB] != TOP_ALL_ONES) |=> s_q.ack == ACK_IDLE)
        else $error("sequencer left idle outside the top address window");

    // no controller select outside the top window either
    AST_TOP_NO_SELECT: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
        (s_q.addr_s2[TOP_MSB:TOP_LSB] != TOP_ALL_ONES) |=> strobe_o.controller_select_n)
        else $error("select given outside the top address window");

    // comparator mismatch never acknowledges
    AST_MID_DECODE: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
        (s_q.addr_s2[MID_MSB:MID_LSB] != mid_match_i) |=> dtack_n_o)
        else $error("acknowledge given with comparator mismatch");

    // low lines play no part, so any alias inside the window starts the sequencer
    AST_ALIAS: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
        (s_q.addr_s2[TOP_MSB:MID_LSB] == {TOP_ALL_ONES, mid_match_i} && any_ds && not_irq_ack) |=> s_q.ack != ACK_IDLE)
        else $error("aliased address inside the window not accepted");

    // acknowledge only follows a qualified cycle of this glue
    AST_ACK_SOURCE: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
        !dtack_n_o |-> $past(qualified))
        else $error("acknowledge low without a qualified cycle");

    // the only way the acknowledge falls is the sequencer stepping into state eleven
    AST_ACK_FROM_SEQ: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
        $fell(dtack_n_o) |-> $past(s_q.ack) == ACK_WAIT2)
        else $error("acknowledge fell outside the sequencer step");

    // without qualification the sequencer returns to idle
    AST_QUAL: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
        !qualified |=> s_q.ack == ACK_IDLE)
        else $error("sequencer advanced without qualification");

    // both data strobes high leaves the cycle unqualified
    AST_QUAL_NEEDS_DS: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
        (s_q.ctl_s2.ds0_n && s_q.ctl_s2.ds1_n) |=> s_q.ack == ACK_IDLE)
        else $error("sequencer advanced with no data strobe");

    // interrupt acknowledge cycles are never answered here
    AST_QUAL_IRQ: assert property (@(posedge clk_i) disable iff (rst_i) // RL5
        !s_q.ctl_s2.irq_ack_cycle_n |=> dtack_n_o)
        else $error("acknowledge given in an interrupt acknowledge cycle");

    // three qualified clocks bring the acknowledge
    AST_ACK_DELAY: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
        (!qualified ##1 qualified [*3]) |=> !dtack_n_o)
        else $error("acknowledge not low three clocks after qualification");

    // two qualified clocks are not enough
    AST_ACK_NOT_EARLY: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
        (!qualified ##1 qualified [*2]) |=> dtack_n_o)
        else $error("acknowledge came early");

    // a falling acknowledge is always preceded by three qualified clocks
    AST_DTACK_THREE: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
        $fell(dtack_n_o) |-> ($past(qualified, 1) && $past(qualified, 2) && $past(qualified, 3)))
        else $error("acknowledge fell before three qualified clocks");

    // acknowledge held while the cycle stays qualified
    AST_ACK_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
        (!dtack_n_o && qualified) |=> !dtack_n_o)
        else $error("acknowledge dropped while still qualified");

    // final state keeps the acknowledge level steady
    AST_DONE_STABLE: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
        (s_q.ack == ACK_DONE && qualified) |=> $stable(dtack_n_o))
        else $error("acknowledge moved in the final state");

    // two flops count up by one or fall back to zero, nothing else
    AST_SEQ_STEP: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
        $changed(s_q.ack) |-> (s_q.ack == ACK_IDLE || 2'(s_q.ack) == 2'($past(s_q.ack)) + 2'b01))
        else $error("sequencer jumped between states");

    // idle steps to the first wait state
    AST_IDLE_STEP: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
        (qualified && s_q.ack == ACK_IDLE) |=> s_q.ack == ACK_WAIT1)
        else $error("sequencer did not leave idle");

    // first wait state steps to the second
    AST_SEQ_ORDER: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
        (qualified && s_q.ack == ACK_WAIT1) |=> s_q.ack == ACK_WAIT2)
        else $error("sequencer skipped a state");

    // second wait state steps to the final one
    AST_WAIT2_STEP: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
        (qualified && s_q.ack == ACK_WAIT2) |=> s_q.ack == ACK_DONE)
        else $error("sequencer did not reach the final state");

    // final state holds while qualified
    AST_DONE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
        (qualified && s_q.ack == ACK_DONE) |=> s_q.ack == ACK_DONE)
        else $error("sequencer left the final state while qualified");

    // losing qualification releases the acknowledge on the next clock
    AST_DTACK_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
        !qualified |=> dtack_n_o)
        else $error("acknowledge still low after qualification ended");

    // while reset is applied everything sits at its idle value
    AST_RESET_IDLE: assert property (@(posedge clk_i) // RL10
        rst_i |-> (s_q.ack == ACK_IDLE && dtack_n_o && strobe_o == STROBE_IDLE && !drv_en_o))
        else $error("outputs not idle during reset");

    // first clock after reset still starts from state zero
    AST_RESET_RELEASE: assert property (@(posedge clk_i) disable iff (rst_i) // RL10
        $fell(rst_i) |-> (s_q.ack == ACK_IDLE && dtack_n_o))
        else $error("sequencer not at zero after reset");

    // acknowledge low exactly in state eleven
    AST_ACK_DECODE: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
        (dtack_n_o == 1'b0) == (s_q.ack == ACK_DONE))
        else $error("acknowledge not tied to state eleven");

    // every other state keeps the acknowledge inactive
    AST_ACK_HIGH_ELSE: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
        (s_q.ack != ACK_DONE) |-> dtack_n_o)
        else $error("acknowledge active outside state eleven");

    // direction high with a data strobe is a read
    AST_RD_WR: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
        (any_ds && s_q.ctl_s2.write_n) |=> (!strobe_o.rd_n && strobe_o.wr_n))
        else $error("read strobe wrong for a read");

    // direction low with a data strobe is a write
    AST_WR_STROBE: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
        (any_ds && !s_q.ctl_s2.write_n) |=> (strobe_o.rd_n && !strobe_o.wr_n))
        else $error("write strobe wrong for a write");

    // no data strobe, no controller read or write strobe
    AST_NO_DS_STROBE: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
        !any_ds |=> (strobe_o.rd_n && strobe_o.wr_n))
        else $error("controller strobe without a data strobe");

    // interrupt acknowledge keeps the select off
    AST_CSEL: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
        !s_q.ctl_s2.irq_ack_cycle_n |=> strobe_o.controller_select_n)
        else $error("select active during interrupt acknowledge");

    // address strobe, board and normal cycle together give the select
    AST_CSEL_ON: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
        (!s_q.ctl_s2.as_n && board_sel && s_q.ctl_s2.irq_ack_cycle_n) |=> !strobe_o.controller_select_n)
        else $error("select missing for a selected cycle");

    // select drops as soon as the address strobe is released
    AST_CSEL_AS: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
        s_q.ctl_s2.as_n |=> strobe_o.controller_select_n)
        else $error("select active without address strobe");

    // drivers stay off outside the dma setup
    AST_DRV: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
        !dma_mode_i |=> !drv_en_o)
        else $error("drivers steered outside dma mode");

    // dma setup enables the drivers on a qualified cycle
    AST_DRV_ON: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
        (dma_mode_i && qualified) |=> drv_en_o)
        else $error("drivers not enabled on a qualified dma cycle");

    // unqualified cycles never open the drivers
    AST_DRV_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
        !qualified |=> !drv_en_o)
        else $error("drivers enabled without qualification");

    // reads point the drivers toward the bus
    AST_DRV_DIR: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
        (dma_mode_i && s_q.ctl_s2.write_n) |=> drv_to_bus_o)
        else $error("drivers not pointed to the bus on a read");

    // writes point the drivers toward the controller
    AST_DRV_WRITE: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
        (dma_mode_i && !s_q.ctl_s2.write_n) |=> !drv_to_bus_o)
        else $error("drivers pointed to the bus on a write");

    // low register select follows the synchronised low lines in dma mode
    AST_LOW_MUX: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
        dma_mode_i |=> reg_sel_o == $past(s_q.addr_s2[LOW_MSB:LOW_LSB]))
        else $error("low register select does not follow address");

    // outside dma mode the low select rests at zero
    AST_LOW_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
        !dma_mode_i |=> reg_sel_o == '0)
        else $error("low register select active outside dma mode");
endmodule

// >>> dv/vme_master_model.sv
module vme_master_model (
    input wire logic clk_i,
    input wire logic dtack_n_i,
    output logic [vme_glue_pkg::ADDR_W-1:0] addr_o,
    output vme_glue_pkg::bus_ctl_t bus_ctl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import vme_glue_pkg::*;

    // bus idles with strobes pulled high
    initial begin
        addr_o = '0;
        bus_ctl_o = BUS_CTL_IDLE;
    end

    // one cycle: strobes held until acknowledge, bounded so a refused cycle gives up
    task automatic xfer(input logic [ADDR_W-1:0] a, input bus_ctl_t c, input int hold, output int lat,
                        output int rel);
        int n;
        n = 0;
        lat = 0;
        rel = 0;
        @(posedge clk_i);
        addr_o <= a;
        bus_ctl_o <= c;
        while (lat == 0 && n < 12) begin
            @(posedge clk_i);
            #1;
            n++;
            if (dtack_n_i === 1'b0) lat = n;
        end
        repeat (hold) @(posedge clk_i); // slow master keeps holding
        @(posedge clk_i);
        addr_o <= ~a; // released lines must not show the stale address
        bus_ctl_o <= BUS_CTL_IDLE;
        while (dtack_n_i !== 1'b1 && rel < 12) begin
            @(posedge clk_i);
            #1;
            rel++;
        end
    endtask
endmodule

// >>> dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vme_glue_pkg::*;

    localparam logic [ADDR_W-1:0] BASE = 24'hFF5A00;
    logic clk_i, rst_i, dma_mode_i, dtack_n_o, drv_en_o, drv_to_bus_o;
    logic [ADDR_W-1:0] addr_i;
    logic [7:0] mid_match_i, snap;
    logic [LOW_MSB-LOW_LSB:0] reg_sel_o;
    bus_ctl_t bus_ctl_i;
    ctl_strobe_t strobe_o;
    int n_mismatch = 0, check_count = 0, cyc = 0, lat, rel, sel_cnt = 0;
    logic [ADDR_W-1:0] bad_a [4] = '{24'hFE5A00, 24'hFF5B00, BASE, BASE};
    bus_ctl_t bad_c [4] = '{5'h07, 5'h07, 5'h0F, 5'h06};

    vme_to_graphics_glue DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .bus_ctl_i(bus_ctl_i),
        .mid_match_i(mid_match_i), .dma_mode_i(dma_mode_i), .dtack_n_o(dtack_n_o), .strobe_o(strobe_o),
        .drv_en_o(drv_en_o), .drv_to_bus_o(drv_to_bus_o), .reg_sel_o(reg_sel_o));
    vme_master_model bus_master (.clk_i(clk_i), .dtack_n_i(dtack_n_o), .addr_o(addr_i), .bus_ctl_o(bus_ctl_i));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // snapshot of controller-side outputs while acknowledged; also the hang limit
    always @(posedge clk_i) begin
        #1;
        cyc++;
        if (dtack_n_o === 1'b0) snap = {strobe_o, drv_en_o, drv_to_bus_o, reg_sel_o};
        if (strobe_o.controller_select_n === 1'b0) sel_cnt++;
        if (cyc == 3000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // read then write back to back, low address bits aliased; 3 clocks plus 2 sync stages
    task automatic t_rd_wr();
        bus_master.xfer(BASE, 5'h07, 4, lat, rel);
        check(8'(lat), 8'd5);
        check(8'(rel), 8'd3);
        check(snap, 8'b001_0_0_000);
        bus_master.xfer(BASE | 24'h00004E, 5'h09, 0, lat, rel);
        check(8'(lat), 8'd5);
        check(snap, 8'b010_0_0_000);
    endtask

    // wrong top byte, wrong middle byte, no data strobe, interrupt acknowledge
    task automatic t_refuse();
        int s0;
        for (int i = 0; i < 4; i++) begin
            s0 = sel_cnt;
            bus_master.xfer(bad_a[i], bad_c[i], 0, lat, rel);
            repeat (3) @(posedge clk_i); // synchronised strobes need three clocks to settle idle
            check(8'(lat), 8'd0);
            check(8'(sel_cnt != s0), 8'(i == 2));
        end
    endtask

    // DMA configuration with a new comparator value: drivers steered, low lines decoded
    task automatic t_dma();
        @(posedge clk_i);
        mid_match_i <= 8'hC3;
        dma_mode_i <= 1'b1;
        bus_master.xfer(24'hFFC30A, 5'h07, 1, lat, rel);
        check(8'(lat), 8'd5);
        check(snap, 8'b001_1_1_101);
        @(posedge clk_i);
        dma_mode_i <= 1'b0;
    endtask

    // reset in mid-transfer clears the sequencer whatever the strobes do
    task automatic t_reset();
        fork
            bus_master.xfer(24'hFFC300, 5'h07, 0, lat, rel);
            begin
                repeat (4) @(posedge clk_i);
                rst_i <= 1'b1;
                repeat (2) @(posedge clk_i);
                #1;
                check({3'b000, dtack_n_o, strobe_o, drv_en_o}, 8'b000_1_111_0);
                @(posedge clk_i);
                rst_i <= 1'b0;
            end
        join
    endtask

    initial begin
        rst_i = 1'b1;
        dma_mode_i = 1'b0;
        mid_match_i = 8'h5A;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_rd_wr();
        t_refuse();
        t_dma();
        t_reset();
        conclude();
    end
endmodule
